// >>> ppim_consts.svh
// Address map, field limits and sizes of the packed process image mapper
`ifndef PPIM_CONSTS_SVH
`define PPIM_CONSTS_SVH
`define PPIM_IN_FIRST   16'h0000
`define PPIM_IN_LAST    16'h01ff
`define PPIM_OUT_FIRST  16'h0800
`define PPIM_OUT_LAST   16'h09ff
`define PPIM_STAT_ADDR  16'h100c
`define PPIM_DIAG_FIRST 16'h1018
`define PPIM_DIAG_LAST  16'h101f
`define PPIM_AREA_REGS  512
`define PPIM_REG_BITS   16
`define PPIM_TRL_MAX    9
`define PPIM_DIAG_MAX   8
`define PPIM_DIG_MAX    32
`define PPIM_INT_MAXB   24
`define PPIM_MAX_SLOTS  32
`endif

// >>> ppim_pkg.sv
// Types shared by the packed process image mapper
package ppim_pkg;
	typedef enum logic [1:0] {
		PPIM_CLS_NONE  = 2'b00,
		PPIM_CLS_DIG   = 2'b01,
		PPIM_CLS_INT   = 2'b10,
		PPIM_CLS_SWIRE = 2'b11
	} ppim_cls_t;
	typedef enum logic [1:0] {
		PPIM_WALK_IDLE = 2'b00,
		PPIM_WALK_INT  = 2'b01,
		PPIM_WALK_DIG  = 2'b10
	} ppim_walk_t;
endpackage : ppim_pkg

// >>> ppim_ram.sv
// One write port, two registered read ports image memory
`timescale 1ns/1ps
module ppim_ram #(
	parameter int W  = 16,
	parameter int D  = 512,
	parameter int AW = $clog2(D)
) (
	// Clock
	input  wire logic          clk_sys_i,
	// Write port
	input  wire logic          wr_en_i,
	input  wire logic [AW-1:0] wr_addr_i,
	input  wire logic [W-1:0]  wr_data_i,
	// Read ports
	input  wire logic          ra_en_i,
	input  wire logic [AW-1:0] ra_addr_i,
	output logic      [W-1:0]  ra_q_o,
	input  wire logic          rb_en_i,
	input  wire logic [AW-1:0] rb_addr_i,
	output logic      [W-1:0]  rb_q_o
);
	logic [W-1:0] mem [D];

	if (D != (1 << AW)) begin : g_chk
		$error("ppim_ram depth must be a power of two");
	end

	always_ff @(posedge clk_sys_i) begin
		if (wr_en_i)
			mem[wr_addr_i] <= wr_data_i;
		if (ra_en_i)
			ra_q_o <= mem[ra_addr_i];
		if (rb_en_i)
			rb_q_o <= mem[rb_addr_i];
	end
endmodule : ppim_ram

// >>> ppim_layout.sv
// Module list and layout walker producing per-slot image offsets
`timescale 1ns/1ps
`include "ppim_consts.svh"
module ppim_layout import ppim_pkg::*; #(
	parameter int SLOTS = 32,
	parameter int SW    = $clog2(SLOTS)
) (
	// Clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        arst_n_i,
	// Module list entry
	input  wire logic        cfg_wr_i,
	input  wire logic [SW-1:0] cfg_slot_i,
	input  wire ppim_cls_t   cfg_cls_i,
	input  wire logic [5:0]  cfg_in_w_i,
	input  wire logic [5:0]  cfg_out_w_i,
	input  wire logic        apply_i,
	// Layout
	output ppim_cls_t        cls_o [SLOTS],
	output logic      [5:0]  in_len_o [SLOTS],
	output logic      [5:0]  out_len_o [SLOTS],
	output logic      [10:0] in_base_o [SLOTS],
	output logic      [10:0] out_base_o [SLOTS],
	output logic      [9:0]  int_in_o,
	output logic      [9:0]  int_out_o,
	output logic      [10:0] dig_in_o,
	output logic      [10:0] dig_out_o,
	output logic             busy_o
);
	if (SLOTS < 2 || SLOTS > `PPIM_MAX_SLOTS || SW != $clog2(SLOTS)) begin : g_chk
		$error("ppim_layout SLOTS or SW out of range");
	end

	logic [5:0]  win [SLOTS];
	logic [5:0]  wout [SLOTS];
	ppim_walk_t  st;
	logic [SW-1:0] idx;
	logic [10:0] acc_in, acc_out;

	// Bytes to whole registers, never zero when any data exists
	function automatic logic [5:0] words(input logic [5:0] b);
		return 6'((7'(b) + 7'd1) >> 1);
	endfunction : words

	function automatic logic is_dig(input ppim_cls_t c);
		return (c == PPIM_CLS_DIG) || (c == PPIM_CLS_SWIRE);
	endfunction : is_dig

	for (genvar i = 0; i < SLOTS; i++) begin : g_len
		assign in_len_o[i]  = (cls_o[i] == PPIM_CLS_INT) ? words(win[i])
			: (is_dig(cls_o[i]) ? win[i] : 6'h00);
		assign out_len_o[i] = (cls_o[i] == PPIM_CLS_INT) ? words(wout[i])
			: (is_dig(cls_o[i]) ? wout[i] : 6'h00);
	end

	wire take = (st == PPIM_WALK_INT) ? (cls_o[idx] == PPIM_CLS_INT) : is_dig(cls_o[idx]);
	wire last = (idx == SW'(SLOTS - 1));
	wire [10:0] next_acc_in  = acc_in + (take ? 11'(in_len_o[idx]) : 11'h000);
	wire [10:0] next_acc_out = acc_out + (take ? 11'(out_len_o[idx]) : 11'h000);
	assign busy_o = (st != PPIM_WALK_IDLE);

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			for (int i = 0; i < SLOTS; i++) begin
				cls_o[i] <= PPIM_CLS_NONE;
				win[i]   <= 6'h00;
				wout[i]  <= 6'h00;
			end
		end else if (cfg_wr_i) begin
			cls_o[cfg_slot_i] <= cfg_cls_i;
			win[cfg_slot_i]   <= cfg_in_w_i;
			wout[cfg_slot_i]  <= cfg_out_w_i;
		end
	end

	// walk slots left to right, intelligent pass first
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st <= PPIM_WALK_IDLE;
			idx <= '0;
			acc_in <= 11'h000;
			acc_out <= 11'h000;
			int_in_o <= 10'h000;
			int_out_o <= 10'h000;
			dig_in_o <= 11'h000;
			dig_out_o <= 11'h000;
			for (int i = 0; i < SLOTS; i++) begin
				in_base_o[i]  <= 11'h000;
				out_base_o[i] <= 11'h000;
			end
		end else if (apply_i) begin
			st <= PPIM_WALK_INT;
			idx <= '0;
			acc_in <= 11'h000;
			acc_out <= 11'h000;
		end else begin
			case (st)
				PPIM_WALK_INT, PPIM_WALK_DIG: begin
					if (take) begin
						in_base_o[idx]  <= acc_in;
						out_base_o[idx] <= acc_out;
					end
					acc_in <= last ? 11'h000 : next_acc_in;
					acc_out <= last ? 11'h000 : next_acc_out;
					idx <= last ? '0 : idx + 1'b1;
					if (last && st == PPIM_WALK_INT) begin
						int_in_o <= next_acc_in[9:0];
						int_out_o <= next_acc_out[9:0];
						st <= PPIM_WALK_DIG;
					end else if (last) begin
						dig_in_o <= next_acc_in;
						dig_out_o <= next_acc_out;
						st <= PPIM_WALK_IDLE;
					end
				end
				default: st <= PPIM_WALK_IDLE;
			endcase
		end
	end
endmodule : ppim_layout

// >>> ppim_mapper.sv
// Packed input/output process image mapper with status/diagnosis trailer
// Behaviour
// - Single-wire bus modules map as digital
// - Intelligent module data first from area base
// - Intelligent modules get whole registers, half the bytes rounded up
// - Eight-byte serial module takes four registers each
// - Order within class follows physical slot order
// - Digital data follows, registers filled completely
// - Digital packing ignores module boundaries
// - Input image 0x0000-0x01FF: intelligent, digital, trailer
// - All input registers readable, unused read zero
// - Trailer at most nine, right after digital
// - First trailer register mirrors station status
// - Next trailer registers hold group diagnosis bits
// - Output image 0x0800-0x09FF: intelligent then digital
// - Unused output registers read zero, writes dropped
// - Widths per module table, digital bitwise
// - Two classes: digital and intelligent
`timescale 1ns/1ps
`include "ppim_consts.svh"
module ppim_mapper import ppim_pkg::*; #(
	parameter int SLOTS = 32,
	parameter int SW    = $clog2(SLOTS)
) (
	// Clock and reset
	input  wire logic          clk_sys_i,
	input  wire logic          arst_n_i,
	// Detected module list
	input  wire logic          cfg_wr_i,
	input  wire logic [SW-1:0] cfg_slot_i,
	input  wire ppim_cls_t     cfg_cls_i,
	input  wire logic [5:0]    cfg_in_w_i,
	input  wire logic [5:0]    cfg_out_w_i,
	input  wire logic          cfg_apply_i,
	output logic               layout_busy_o,
	// Module input data
	input  wire logic          mi_wr_i,
	input  wire logic [SW-1:0] mi_slot_i,
	input  wire logic [3:0]    mi_word_i,
	input  wire logic [31:0]   mi_data_i,
	// Module output data
	input  wire logic          mo_rd_i,
	input  wire logic [SW-1:0] mo_slot_i,
	input  wire logic [3:0]    mo_word_i,
	output logic               mo_valid_o,
	output logic      [31:0]   mo_data_o,
	// Station state
	input  wire logic [15:0]   station_status_word_i,
	input  wire logic [SLOTS-1:0] module_group_diag_bits_i,
	// Client register access
	input  wire logic          cl_rd_i,
	input  wire logic          cl_wr_i,
	input  wire logic [15:0]   cl_addr_i,
	input  wire logic [15:0]   cl_wdata_i,
	output logic               cl_rvalid_o,
	output logic      [15:0]   cl_rdata_o
);
	localparam int DV = SLOTS * `PPIM_DIG_MAX;
	localparam int DR = SLOTS / `PPIM_REG_BITS;

	if (SLOTS == 0 || SLOTS > `PPIM_MAX_SLOTS || SLOTS % `PPIM_REG_BITS != 0 || DR + 1 > `PPIM_TRL_MAX
			|| SW != $clog2(SLOTS)) begin : g_chk
		$error("ppim_mapper SLOTS must be 16 or 32, SW its log2");
	end

	ppim_cls_t   cls [SLOTS];
	logic [5:0]  in_len [SLOTS];
	logic [5:0]  out_len [SLOTS];
	logic [10:0] in_base [SLOTS];
	logic [10:0] out_base [SLOTS];
	logic [9:0]  int_in, int_out;
	logic [10:0] dig_in, dig_out;
	logic [DV-1:0] dvec_in, dvec_out;
	logic [15:0] hold, mem_in_q, mem_out_q, mo_mem_q;
	logic        sel_in_mem, sel_out_mem, mo_sel_mem, mo_zero;
	logic [31:0] mo_dig;
	logic [`PPIM_AREA_REGS-1:0] in_live, out_live;

	ppim_layout #(
		.SLOTS (SLOTS),
		.SW    (SW)
	) u_layout (
		.clk_sys_i  (clk_sys_i),
		.arst_n_i   (arst_n_i),
		.cfg_wr_i   (cfg_wr_i),
		.cfg_slot_i (cfg_slot_i),
		.cfg_cls_i  (cfg_cls_i),
		.cfg_in_w_i (cfg_in_w_i),
		.cfg_out_w_i(cfg_out_w_i),
		.apply_i    (cfg_apply_i),
		.cls_o      (cls),
		.in_len_o   (in_len),
		.out_len_o  (out_len),
		.in_base_o  (in_base),
		.out_base_o (out_base),
		.int_in_o   (int_in),
		.int_out_o  (int_out),
		.dig_in_o   (dig_in),
		.dig_out_o  (dig_out),
		.busy_o     (layout_busy_o)
	);

	// Low mask of n bits within the packed digital vector
	function automatic logic [DV-1:0] lowmask(input logic [10:0] n);
		return ~({DV{1'b1}} << n);
	endfunction : lowmask

	function automatic logic [15:0] reg_of(input logic [DV-1:0] v, input logic [9:0] k);
		return 16'(v >> {k, 4'h0});
	endfunction : reg_of

	// Registers occupied by a digital bit count
	function automatic logic [9:0] regs_of(input logic [10:0] bits);
		return 10'((12'(bits) + 12'd15) >> 4);
	endfunction : regs_of

	function automatic logic is_dig(input ppim_cls_t c);
		return (c == PPIM_CLS_DIG) || (c == PPIM_CLS_SWIRE);
	endfunction : is_dig

	// Analog, serial and technology modules take whole registers
	function automatic logic is_int(input ppim_cls_t c);
		return c == PPIM_CLS_INT;
	endfunction : is_int

	// Client address decode
	wire [9:0] idx      = {1'b0, cl_addr_i[8:0]};
	wire       in_hit   = (cl_addr_i <= `PPIM_IN_LAST);
	wire       out_hit  = (cl_addr_i >= `PPIM_OUT_FIRST) && (cl_addr_i <= `PPIM_OUT_LAST);
	wire       stat_hit = (cl_addr_i == `PPIM_STAT_ADDR);
	wire       diag_hit = (cl_addr_i >= `PPIM_DIAG_FIRST) && (cl_addr_i <= `PPIM_DIAG_LAST);
	wire [9:0] din_end  = int_in + regs_of(dig_in);
	wire [9:0] dout_end = int_out + regs_of(dig_out);
	wire [9:0] trl_off  = idx - din_end;
	wire       in_int   = in_hit && (idx < int_in);
	wire       in_dig   = in_hit && !in_int && (idx < din_end);
	wire       in_trl   = in_hit && (idx >= din_end) && (trl_off < 10'(DR + 1));
	wire       out_int  = out_hit && (idx < int_out);
	wire       out_dig  = out_hit && !out_int && (idx < dout_end);
	wire [2:0] diag_k   = cl_addr_i[2:0];

	// group diagnosis registers, slots beyond station read zero
	wire [`PPIM_DIAG_MAX*16-1:0] diag_ext = (`PPIM_DIAG_MAX*16)'(module_group_diag_bits_i);
	wire [15:0] diag_word = diag_ext[{diag_k, 4'h0} +: 16];

	wire [15:0] trl_word = (trl_off == 10'h000) ? station_status_word_i
		: diag_ext[{trl_off[2:0] - 3'd1, 4'h0} +: 16];

	// digital registers count from end of intelligent area
	wire [15:0] din_word  = reg_of(dvec_in, idx - int_in);
	wire [15:0] dout_word = reg_of(dvec_out, idx - int_out);

	wire [15:0] next_hold = in_dig ? din_word
		: in_trl ? trl_word
		: out_dig ? dout_word
		: stat_hit ? station_status_word_i
		: diag_hit ? diag_word
		: 16'h0000;

	// unwritten intelligent words fall back to hold, which is zero there
	wire       rd_in_mem  = in_int && in_live[idx[8:0]];
	wire       rd_out_mem = out_int && out_live[idx[8:0]];

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cl_rvalid_o <= 1'b0;
			hold <= 16'h0000;
			sel_in_mem <= 1'b0;
			sel_out_mem <= 1'b0;
		end else begin
			cl_rvalid_o <= cl_rd_i;
			if (cl_rd_i) begin
				hold <= next_hold;
				sel_in_mem <= rd_in_mem;
				sel_out_mem <= rd_out_mem;
			end
		end
	end

	assign cl_rdata_o = sel_in_mem ? mem_in_q : (sel_out_mem ? mem_out_q : hold);

	// Module input path
	// offsets move during a walk; writes then would land in stale places
	wire        walk_idle = !layout_busy_o && !cfg_apply_i;
	wire        mi_int   = is_int(cls[mi_slot_i]);
	wire        mi_digc  = is_dig(cls[mi_slot_i]);
	// word index must lie inside the allotment
	wire        mi_int_wr = mi_wr_i && walk_idle && mi_int && (6'(mi_word_i) < in_len[mi_slot_i]);
	wire [10:0] mi_addr  = in_base[mi_slot_i] + 11'(mi_word_i);
	wire [DV-1:0] mi_mask = lowmask(11'(in_len[mi_slot_i])) << in_base[mi_slot_i];
	// channel 0 lands on next free bit
	wire [DV-1:0] mi_bits = DV'(mi_data_i) << in_base[mi_slot_i];

	// Client output writes; only used bits of the last digital register take data
	// a write beside a read, or during a walk, is dropped
	wire          cl_wr_ok = cl_wr_i && !cl_rd_i && walk_idle;
	wire          cl_out_int_wr = cl_wr_ok && out_int;
	wire [DV-1:0] cl_mask = lowmask(dig_out) & (DV'(16'hffff) << {idx - int_out, 4'h0});
	wire [DV-1:0] cl_bits = DV'(cl_wdata_i) << {idx - int_out, 4'h0};

	// Digital vectors start empty after every relayout, offsets have moved
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			dvec_in <= '0;
			dvec_out <= '0;
		end else if (cfg_apply_i) begin
			dvec_in <= '0;
			dvec_out <= '0;
		end else begin
			if (mi_wr_i && walk_idle && mi_digc)
				dvec_in <= (dvec_in & ~mi_mask) | (mi_bits & mi_mask);
			if (cl_wr_ok && out_dig)
				dvec_out <= (dvec_out & ~cl_mask) | (cl_bits & cl_mask);
		end
	end

	// words not written since the last apply read zero, never a word of an older layout
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			in_live <= '0;
			out_live <= '0;
		end else if (cfg_apply_i) begin
			in_live <= '0;
			out_live <= '0;
		end else begin
			if (mi_int_wr)
				in_live[mi_addr[8:0]] <= 1'b1;
			if (cl_out_int_wr)
				out_live[idx[8:0]] <= 1'b1;
		end
	end

	// intelligent words held in image memories
	ppim_ram #(
		.W (16),
		.D (`PPIM_AREA_REGS)
	) u_in_ram (
		.clk_sys_i (clk_sys_i),
		.wr_en_i   (mi_int_wr),
		.wr_addr_i (mi_addr[8:0]),
		.wr_data_i (mi_data_i[15:0]),
		.ra_en_i   (cl_rd_i),
		.ra_addr_i (idx[8:0]),
		.ra_q_o    (mem_in_q),
		.rb_en_i   (1'b0),
		.rb_addr_i (9'h000),
		.rb_q_o    ()
	);

	// Module output path
	wire        mo_int  = is_int(cls[mo_slot_i]);
	wire [10:0] mo_addr = out_base[mo_slot_i] + 11'(mo_word_i);
	wire        mo_ok   = mo_int && (6'(mo_word_i) < out_len[mo_slot_i]) && out_live[mo_addr[8:0]];
	// digital channels bitwise, intelligent words whole
	wire [31:0] mo_bits = 32'((dvec_out >> out_base[mo_slot_i]) & lowmask(11'(out_len[mo_slot_i])));

	ppim_ram #(
		.W (16),
		.D (`PPIM_AREA_REGS)
	) u_out_ram (
		.clk_sys_i (clk_sys_i),
		.wr_en_i   (cl_out_int_wr),
		.wr_addr_i (idx[8:0]),
		.wr_data_i (cl_wdata_i),
		.ra_en_i   (cl_rd_i),
		.ra_addr_i (idx[8:0]),
		.ra_q_o    (mem_out_q),
		.rb_en_i   (mo_rd_i),
		.rb_addr_i (mo_addr[8:0]),
		.rb_q_o    (mo_mem_q)
	);

	// Module output answer, one cycle after the request
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mo_valid_o <= 1'b0;
			mo_sel_mem <= 1'b0;
			mo_zero <= 1'b1;
			mo_dig <= 32'h0000_0000;
		end else begin
			mo_valid_o <= mo_rd_i;
			if (mo_rd_i) begin
				mo_sel_mem <= mo_int;
				mo_zero <= mo_int && !mo_ok;
				mo_dig <= mo_int ? 32'h0000_0000 : mo_bits;
			end
		end
	end

	assign mo_data_o = mo_zero ? 32'h0000_0000 : (mo_sel_mem ? {16'h0000, mo_mem_q} : mo_dig);
endmodule : ppim_mapper

// >>> ppim_mapper_checker.sv
// Port checker for the packed process image mapper
`timescale 1ns/1ps
`include "ppim_consts.svh"
module ppim_mapper_checker #(
	parameter int SLOTS = 32
) (
	// Clock and reset
	input wire logic             clk_sys_i,
	input wire logic             arst_n_i,
	// Layout control
	input wire logic             cfg_apply_i,
	input wire logic             layout_busy_o,
	// Module output side
	input wire logic             mo_rd_i,
	input wire logic             mo_valid_o,
	// Station state
	input wire logic [15:0]      station_status_word_i,
	input wire logic [SLOTS-1:0] module_group_diag_bits_i,
	// Client port
	input wire logic             cl_rd_i,
	input wire logic [15:0]      cl_addr_i,
	input wire logic             cl_rvalid_o,
	input wire logic [15:0]      cl_rdata_o
);
	logic [7:0] busy_cnt;

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!arst_n_i);

	// Walk length restarts with every apply, as a new apply restarts the walk
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i)
			busy_cnt <= 8'h00;
		else if (cfg_apply_i || !layout_busy_o)
			busy_cnt <= 8'h00;
		else
			busy_cnt <= busy_cnt + 8'h01;
	end

	a_read_answer: assert property (cl_rd_i |=> cl_rvalid_o)
		else $error("read not answered one cycle later");
	a_answer_cause: assert property (cl_rvalid_o |-> $past(cl_rd_i))
		else $error("read answer without a read");
	a_rdata_hold: assert property (!cl_rd_i |=> $stable(cl_rdata_o))
		else $error("read data moved without a read");
	a_gap_zero: assert property (cl_rd_i && cl_addr_i > `PPIM_IN_LAST && cl_addr_i < `PPIM_OUT_FIRST
		|=> cl_rdata_o == 16'h0000) else $error("unmapped register not zero");
	a_status_mirror: assert property (cl_rd_i && cl_addr_i == `PPIM_STAT_ADDR
		|=> cl_rdata_o == $past(station_status_word_i)) else $error("status register mismatch");
	a_diag_mirror: assert property (cl_rd_i && cl_addr_i == `PPIM_DIAG_FIRST
		|=> cl_rdata_o == $past(module_group_diag_bits_i[15:0])) else $error("diagnosis register mismatch");
	a_diag_spare: assert property (cl_rd_i && cl_addr_i > `PPIM_DIAG_FIRST + SLOTS / 16 - 1
		&& cl_addr_i <= `PPIM_DIAG_LAST |=> cl_rdata_o == 16'h0000) else $error("spare diagnosis not zero");
	a_walk_start: assert property (cfg_apply_i |=> layout_busy_o)
		else $error("layout walk did not start");
	a_walk_length: assert property ($fell(layout_busy_o) |-> busy_cnt == 2 * SLOTS)
		else $error("layout walk length wrong");
	a_out_answer: assert property (mo_rd_i |=> mo_valid_o)
		else $error("module output read not answered");
endmodule : ppim_mapper_checker

bind ppim_mapper ppim_mapper_checker #(.SLOTS(SLOTS)) u_ppim_mapper_checker (
	.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .cfg_apply_i(cfg_apply_i), .layout_busy_o(layout_busy_o),
	.mo_rd_i(mo_rd_i), .mo_valid_o(mo_valid_o), .station_status_word_i(station_status_word_i),
	.module_group_diag_bits_i(module_group_diag_bits_i), .cl_rd_i(cl_rd_i), .cl_addr_i(cl_addr_i),
	.cl_rvalid_o(cl_rvalid_o), .cl_rdata_o(cl_rdata_o));

// >>> ppim_client.sv
// Register client model that reads and writes the process images
`timescale 1ns/1ps
module ppim_client (
	// Clock
	input  wire logic        clk_sys_i,
	// Register port
	output logic             cl_rd_o,
	output logic             cl_wr_o,
	output logic [15:0]      cl_addr_o,
	output logic [15:0]      cl_wdata_o,
	input  wire logic        cl_rvalid_i,
	input  wire logic [15:0] cl_rdata_i
);
	initial begin
		cl_rd_o = 1'b0;
		cl_wr_o = 1'b0;
		cl_addr_o = 16'h0000;
		cl_wdata_o = 16'h0000;
	end

	// Strobe stays up so back-to-back writes never assign it twice in one step
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		cl_rd_o <= 1'b0;
		cl_wr_o <= 1'b1;
		cl_addr_o <= a;
		cl_wdata_o <= d;
		@(posedge clk_sys_i);
	endtask : wr

	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		bit got;
		got = 1'b0;
		d = 16'hxxxx;
		cl_wr_o <= 1'b0;
		cl_rd_o <= 1'b1;
		cl_addr_o <= a;
		@(posedge clk_sys_i);
		cl_rd_o <= 1'b0;
		cl_addr_o <= ~a;
		cl_wdata_o <= ~cl_wdata_o;
		for (int n = 0; n < 4 && !got; n++) begin
			@(posedge clk_sys_i);
			if (cl_rvalid_i === 1'b1) begin
				d = cl_rdata_i;
				got = 1'b1;
			end
		end
	endtask : rd
endmodule : ppim_client

// >>> ppim_mapper_tb.sv
// Self-checking bench for the packed process image mapper
`timescale 1ns/1ps
`include "ppim_consts.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
	$display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module ppim_mapper_tb import ppim_pkg::*;;
	localparam int SLOTS = 16;
	localparam int LIMIT = 30000;
	logic             clk_sys_i = 1'b0;
	logic             arst_n_i, cfg_wr_i, cfg_apply_i, mi_wr_i, mo_rd_i, layout_busy_o, mo_valid_o;
	logic             cl_rd_i, cl_wr_i, cl_rvalid_o;
	logic [3:0]       cfg_slot_i, mi_slot_i, mo_slot_i, mi_word_i, mo_word_i;
	ppim_cls_t        cfg_cls_i;
	logic [5:0]       cfg_in_w_i, cfg_out_w_i;
	logic [31:0]      mi_data_i, mo_data_o;
	logic [15:0]      stat, cl_addr_i, cl_wdata_i, cl_rdata_o, rd;
	logic [SLOTS-1:0] diag;
	int               seed = 97, mismatches = 0, samples_checked = 0, cycles = 0, ai, ao, bi, bo;
	int               cls[SLOTS], wi[SLOTS], wo[SLOTS], ib[SLOTS], ob[SLOTS], dbi[SLOTS], dbo[SLOTS];
	logic [15:0]      iw[SLOTS][16];
	logic [31:0]      dv[SLOTS];
	logic [15:0]      oimg[512];

	ppim_mapper #(.SLOTS(SLOTS)) u_ppim_mapper (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
		.cfg_wr_i(cfg_wr_i), .cfg_slot_i(cfg_slot_i), .cfg_cls_i(cfg_cls_i), .cfg_in_w_i(cfg_in_w_i),
		.cfg_out_w_i(cfg_out_w_i), .cfg_apply_i(cfg_apply_i), .layout_busy_o(layout_busy_o),
		.mi_wr_i(mi_wr_i), .mi_slot_i(mi_slot_i), .mi_word_i(mi_word_i), .mi_data_i(mi_data_i),
		.mo_rd_i(mo_rd_i), .mo_slot_i(mo_slot_i), .mo_word_i(mo_word_i), .mo_valid_o(mo_valid_o),
		.mo_data_o(mo_data_o), .station_status_word_i(stat), .module_group_diag_bits_i(diag),
		.cl_rd_i(cl_rd_i), .cl_wr_i(cl_wr_i), .cl_addr_i(cl_addr_i), .cl_wdata_i(cl_wdata_i),
		.cl_rvalid_o(cl_rvalid_o), .cl_rdata_o(cl_rdata_o));
	ppim_client u_ppim_client (.clk_sys_i(clk_sys_i), .cl_rd_o(cl_rd_i), .cl_wr_o(cl_wr_i),
		.cl_addr_o(cl_addr_i), .cl_wdata_o(cl_wdata_i), .cl_rvalid_i(cl_rvalid_o), .cl_rdata_i(cl_rdata_o));

	always #50 clk_sys_i = ~clk_sys_i;

	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == LIMIT) begin
			mismatches++;
			end_sim();
		end
	end

	function automatic int rnd(int n);
		return $unsigned($random(seed)) % n;
	endfunction : rnd

	// intelligent words first, digital bits after, both in slot order
	function automatic void plan();
		ai = 0; ao = 0; bi = 0; bo = 0;
		for (int s = 0; s < SLOTS; s++) if (cls[s] == 2) begin
			ib[s] = ai; ob[s] = ao; ai += (wi[s] + 1) / 2; ao += (wo[s] + 1) / 2;
		end
		for (int s = 0; s < SLOTS; s++) if (cls[s] % 2 == 1) begin
			dbi[s] = bi; dbo[s] = bo; bi += wi[s]; bo += wo[s];
		end
		foreach (oimg[o]) oimg[o] = 16'h0000;
	endfunction : plan

	// packed bits ignore module edges, trailer right after them
	function automatic logic [15:0] exp_in(int r);
		logic [15:0] v = 16'h0000;
		for (int s = 0; s < SLOTS; s++) begin
			if (cls[s] == 2 && r >= ib[s] && r < ib[s] + (wi[s] + 1) / 2) v = iw[s][r - ib[s]];
			for (int b = 0; b < 16; b++)
				if (cls[s] % 2 == 1 && (r - ai) * 16 + b >= dbi[s] && (r - ai) * 16 + b < dbi[s] + wi[s])
					v[b] = dv[s][(r - ai) * 16 + b - dbi[s]];
		end
		if (r == ai + (bi + 15) / 16) v = stat;
		if (r == ai + (bi + 15) / 16 + 1) v = diag;
		return v;
	endfunction : exp_in

	task automatic configure(input bit fixed);
		int n;
		int dw[6] = '{0, 2, 4, 8, 16, 32};
		for (int s = 0; s < SLOTS; s++) begin
			cls[s] = rnd(4);
			wi[s] = cls[s] == 2 ? rnd(25) : dw[rnd(6)];
			wo[s] = cls[s] == 2 ? rnd(25) : dw[rnd(6)];
			if (fixed && s < 2) begin
				cls[s] = 3 - s; wi[s] = 8; wo[s] = 8;
			end
			cfg_wr_i <= 1'b1; cfg_slot_i <= 4'(s); cfg_cls_i <= ppim_cls_t'(2'(cls[s]));
			cfg_in_w_i <= 6'(wi[s]); cfg_out_w_i <= 6'(wo[s]);
			@(posedge clk_sys_i);
		end
		cfg_wr_i <= 1'b0;
		cfg_apply_i <= 1'b1;
		stat <= 16'($random(seed));
		diag <= SLOTS'($random(seed));
		@(posedge clk_sys_i);
		cfg_apply_i <= 1'b0;
		n = 0;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (layout_busy_o !== 1'b0 && n < 100);
		`CHK(n, 2 * SLOTS + 1)
		plan();
	endtask : configure

	task automatic load_inputs();
		for (int s = 0; s < SLOTS; s++) begin
			dv[s] = $random(seed);
			// One word past the allotment is sent too and must be dropped
			for (int k = 0; k <= (cls[s] == 2 ? (wi[s] + 1) / 2 : 0) && k < 16; k++) begin
				iw[s][k] = 16'($random(seed));
				mi_wr_i <= 1'b1; mi_slot_i <= 4'(s); mi_word_i <= 4'(k);
				mi_data_i <= cls[s] == 2 ? {~iw[s][k], iw[s][k]} : dv[s];
				@(posedge clk_sys_i);
			end
		end
		mi_wr_i <= 1'b0;
	endtask : load_inputs

	task automatic check_images();
		logic [15:0] d;
		logic [31:0] e;
		u_ppim_client.wr(16'h0000, 16'hffff);
		for (int r = 0; r < 512; r++) begin
			u_ppim_client.rd(16'(r), rd);
			`CHK(rd, exp_in(r))
		end
		u_ppim_client.rd(`PPIM_STAT_ADDR, rd);
		`CHK(rd, stat)
		u_ppim_client.rd(`PPIM_DIAG_FIRST, rd);
		`CHK(rd, diag)
		u_ppim_client.rd(`PPIM_DIAG_FIRST + 16'h0001, rd);
		`CHK(rd, 16'h0000)
		u_ppim_client.rd(16'h0400, rd);
		`CHK(rd, 16'h0000)
		for (int o = 0; o < 512; o++) begin
			d = 16'($random(seed));
			u_ppim_client.wr(`PPIM_OUT_FIRST + 16'(o), d);
			for (int b = 0; b < 16; b++)
				if (o < ao || (o < ao + (bo + 15) / 16 && (o - ao) * 16 + b < bo)) oimg[o][b] = d[b];
		end
		for (int o = 0; o < 512; o++) begin
			u_ppim_client.rd(`PPIM_OUT_FIRST + 16'(o), rd);
			`CHK(rd, oimg[o])
		end
		for (int s = 0; s < SLOTS; s++)
			for (int k = 0; k <= (cls[s] == 2 ? (wo[s] + 1) / 2 : 0) && k < 16; k++) begin
				e = 32'h0000_0000;
				if (cls[s] == 2 && k < (wo[s] + 1) / 2) e[15:0] = oimg[ob[s] + k];
				if (cls[s] % 2 == 1)
					for (int c = 0; c < wo[s]; c++) e[c] = oimg[ao + (dbo[s] + c) / 16][(dbo[s] + c) % 16];
				mo_rd_i <= 1'b1; mo_slot_i <= 4'(s); mo_word_i <= 4'(k);
				@(posedge clk_sys_i);
				mo_rd_i <= 1'b0;
				@(posedge clk_sys_i);
				`CHK(mo_valid_o, 1'b1)
				`CHK(mo_data_o, e)
			end
	endtask : check_images

	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : end_sim

	initial begin
		arst_n_i = 1'b0; cfg_wr_i = 1'b0; cfg_apply_i = 1'b0; mi_wr_i = 1'b0; mo_rd_i = 1'b0;
		cfg_slot_i = 4'h0; mi_slot_i = 4'h0; mo_slot_i = 4'h0; mi_word_i = 4'h0; mo_word_i = 4'h0;
		cfg_cls_i = PPIM_CLS_NONE; cfg_in_w_i = 6'h00; cfg_out_w_i = 6'h00; mi_data_i = 32'h0000_0000;
		stat = 16'h0000; diag = '0;
		repeat (5) @(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		for (int round = 0; round < 3; round++) begin
			configure(round == 0);
			load_inputs();
			check_images();
		end
		end_sim();
	end
endmodule : ppim_mapper_tb
